// ==== mfpr_defs.vh ====
// mfpr_defs.vh: register offsets, field positions, codes and reset values
// assumes: included by the multifunction pin router files by bare name
`ifndef MFPR_DEFS_VH
`define MFPR_DEFS_VH
// register offsets
`define MFPR_ADDR_CLK_SRC 8'h04
`define MFPR_ADDR_AUD_DIR 8'h1B
`define MFPR_ADDR_SEC_SRC 8'h1F
`define MFPR_ADDR_DOUT_CTL 8'h21
`define MFPR_ADDR_GPIO_FN 8'h34
`define MFPR_ADDR_GPIO_SRC 8'h35
`define MFPR_ADDR_DIN_FN 8'h36
`define MFPR_ADDR_SOUT_FN 8'h37
`define MFPR_ADDR_SCLK_FN 8'h38
// reset values
`define MFPR_RST_REG 8'h00
// field positions
`define MFPR_CGEN_HI 3
`define MFPR_CGEN_LO 2
`define MFPR_CONV_HI 1
`define MFPR_CONV_LO 0
`define MFPR_BCLK_DIR 3
`define MFPR_WCLK_DIR 2
`define MFPR_SBCLK_HI 6
`define MFPR_SBCLK_LO 5
`define MFPR_SWCLK_HI 4
`define MFPR_SWCLK_LO 3
`define MFPR_SDIN_SEL 0
`define MFPR_FN4_HI 5
`define MFPR_FN4_LO 2
`define MFPR_SRC_HI 3
`define MFPR_SRC_LO 1
`define MFPR_GP_LEVEL 0
`define MFPR_SO_HI 4
`define MFPR_SO_LO 1
`define MFPR_FN2_HI 2
`define MFPR_FN2_LO 1
`define MFPR_LVL_BIT 0
// clock selects
`define MFPR_CS_MCLK 2'h0
`define MFPR_CS_BCLK 2'h1
`define MFPR_CS_GPIO 2'h2
`define MFPR_CS_DIN 2'h3
// two-bit pin functions
`define MFPR_F2_SERIAL 2'h1
`define MFPR_F2_GPI 2'h2
// gpio/data-out pin functions
`define MFPR_GF_CLKIN 4'h1
`define MFPR_GF_GPI 4'h2
`define MFPR_GF_AUX 4'h4
`define MFPR_GF_FIRST_INTERRUPT 4'h5
`define MFPR_GF_SECOND_INTERRUPT 4'h6
`define MFPR_GF_SBCLK 4'h8
`define MFPR_GF_SWCLK 4'h9
`define MFPR_GF_DOUT 4'hE
// gpio/data-out output sources
`define MFPR_GS_DOUT 3'h1
`define MFPR_GS_GPO 3'h2
// serial-out pin functions
`define MFPR_SF_GPO 4'h2
`define MFPR_SF_AUX 4'h3
`define MFPR_SF_FIRST_INTERRUPT 4'h4
`define MFPR_SF_SECOND_INTERRUPT 4'h5
`define MFPR_SF_SDOUT 4'h8
`define MFPR_SF_SBCLK 4'h9
`define MFPR_SF_SWCLK 4'hA
// secondary clock source codes
`define MFPR_SS_GPIO 2'h0
`define MFPR_SS_SCLK 2'h1
`endif

// ==== mfpr_pin_peer.sv ====
// mfpr_pin_peer.sv: board-side peers on the router's multifunction pins
// assumes: peer levels come from the bench; peers release a shared pin the router drives
`timescale 1ns/1ps
module mfpr_pin_peer (
  input wire [5:0] peer_lvl_in,
  input wire dev_bclk_in,
  input wire dev_bclk_oe_n_in,
  input wire dev_wclk_in,
  input wire dev_wclk_oe_n_in,
  input wire dev_gpio_in,
  input wire dev_gpio_oe_n_in,
  output wire [5:0] pin_lvl_out
);
  // a shared pin carries the router value while its enable is low
  assign pin_lvl_out[0] = peer_lvl_in[0];
  assign pin_lvl_out[1] = dev_bclk_oe_n_in ? peer_lvl_in[1] : dev_bclk_in;
  assign pin_lvl_out[2] = dev_wclk_oe_n_in ? peer_lvl_in[2] : dev_wclk_in;
  assign pin_lvl_out[3] = peer_lvl_in[3];
  assign pin_lvl_out[4] = dev_gpio_oe_n_in ? peer_lvl_in[4] : dev_gpio_in;
  assign pin_lvl_out[5] = peer_lvl_in[5];
endmodule // mfpr_pin_peer

// ==== mfpr_router.v ====
// mfpr_router.v: multifunction pin router with its selection registers
// assumes: one 10 MHz clock, register port driven by the control-bus logic,
// internal sources (clocks, interrupts, data) are on the same clock
`timescale 1ns/1ps
`include "mfpr_defs.vh"
module mfpr_router (
  input wire sys_clk_in,
  input wire rst_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  input wire mclk_pin_in,
  input wire bclk_pin_in,
  output reg bclk_pin_out,
  output reg bclk_pin_oe_n_out,
  input wire wclk_pin_in,
  output reg wclk_pin_out,
  output reg wclk_pin_oe_n_out,
  input wire data_in_pin_in,
  input wire gpio_pin_in,
  output reg gpio_pin_out,
  output reg gpio_pin_oe_n_out,
  input wire sclk_pin_in,
  output reg sout_pin_out,
  output reg sout_pin_oe_n_out,
  input wire pri_bclk_in,
  input wire pri_wclk_in,
  input wire pri_dout_in,
  input wire aux_clk_in,
  input wire first_interrupt_in,
  input wire second_interrupt_in,
  input wire sec_bclk_in,
  input wire sec_wclk_in,
  input wire sec_dout_in,
  output reg cgen_clk_out,
  output reg conv_clk_out,
  output reg pri_bclk_out,
  output reg pri_wclk_out,
  output reg pri_din_out,
  output reg sec_bclk_out,
  output reg sec_wclk_out,
  output reg sec_din_out,
  output reg dout_keep_out
);
  reg [7:0] clk_src_r;
  reg [7:0] aud_dir_r;
  reg [7:0] sec_src_r;
  reg [7:0] dout_ctl_r;
  reg [7:0] gpio_fn_r;
  reg [7:0] gpio_src_r;
  reg [7:0] din_fn_r;
  reg [7:0] sout_fn_r;
  reg [7:0] sclk_fn_r;
  wire [5:0] pin_sync;
  wire mclk_s;
  wire bclk_s;
  wire wclk_s;
  wire din_s;
  wire gpio_s;
  wire sclk_s;
  wire [1:0] cgen_sel;
  wire [1:0] conv_sel;
  wire [3:0] gpio_fn;
  wire [2:0] gpio_src;
  wire [1:0] din_fn;
  wire [3:0] sout_fn;
  wire [1:0] sclk_fn;
  wire gpio_is_in;
  wire sclk_is_in;
  reg gpio_drv_nxt;
  reg gpio_val_nxt;
  reg sout_drv_nxt;
  reg sout_val_nxt;
  reg cgen_nxt;
  reg conv_nxt;
  reg sbclk_nxt;
  reg swclk_nxt;
  reg sdin_nxt;
  reg [7:0] rdata_nxt;

  // pin levels cross into the clock domain through two flops each
  mfpr_sync #(
    .W(6)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .async_in({sclk_pin_in, gpio_pin_in, data_in_pin_in, wclk_pin_in, bclk_pin_in, mclk_pin_in}),
    .sync_out(pin_sync)
  );
  assign mclk_s = pin_sync[0];
  assign bclk_s = pin_sync[1];
  assign wclk_s = pin_sync[2];
  assign din_s = pin_sync[3];
  assign gpio_s = pin_sync[4];
  assign sclk_s = pin_sync[5];

  // field extraction
  assign cgen_sel = clk_src_r[`MFPR_CGEN_HI:`MFPR_CGEN_LO];
  assign conv_sel = clk_src_r[`MFPR_CONV_HI:`MFPR_CONV_LO];
  assign gpio_fn = gpio_fn_r[`MFPR_FN4_HI:`MFPR_FN4_LO];
  assign gpio_src = gpio_src_r[`MFPR_SRC_HI:`MFPR_SRC_LO];
  assign din_fn = din_fn_r[`MFPR_FN2_HI:`MFPR_FN2_LO];
  assign sout_fn = sout_fn_r[`MFPR_SO_HI:`MFPR_SO_LO];
  assign sclk_fn = sclk_fn_r[`MFPR_FN2_HI:`MFPR_FN2_LO];
  // gpio and serial-clock pins count as inputs only under an input function
  assign gpio_is_in = (gpio_fn == `MFPR_GF_CLKIN);
  assign sclk_is_in = (sclk_fn == `MFPR_F2_SERIAL);

  // register writes; fields hold until rewritten or reset
  always @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      clk_src_r <= `MFPR_RST_REG;
      aud_dir_r <= `MFPR_RST_REG;
      sec_src_r <= `MFPR_RST_REG;
      dout_ctl_r <= `MFPR_RST_REG;
      gpio_fn_r <= `MFPR_RST_REG;
      gpio_src_r <= `MFPR_RST_REG;
      din_fn_r <= `MFPR_RST_REG;
      sout_fn_r <= `MFPR_RST_REG;
      sclk_fn_r <= `MFPR_RST_REG;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        `MFPR_ADDR_CLK_SRC: clk_src_r <= reg_wdata_in;
        `MFPR_ADDR_AUD_DIR: aud_dir_r <= reg_wdata_in;
        `MFPR_ADDR_SEC_SRC: sec_src_r <= reg_wdata_in;
        `MFPR_ADDR_DOUT_CTL: dout_ctl_r <= reg_wdata_in;
        `MFPR_ADDR_GPIO_FN: gpio_fn_r <= reg_wdata_in;
        `MFPR_ADDR_GPIO_SRC: gpio_src_r <= reg_wdata_in;
        `MFPR_ADDR_DIN_FN: din_fn_r <= reg_wdata_in;
        `MFPR_ADDR_SOUT_FN: sout_fn_r <= reg_wdata_in;
        `MFPR_ADDR_SCLK_FN: sclk_fn_r <= reg_wdata_in;
        default: clk_src_r <= clk_src_r;
      endcase
    end
  end

  // clock-generator and converter clock selection; both may pick mclk
  always @*
  begin
    case (cgen_sel)
      `MFPR_CS_MCLK: cgen_nxt = mclk_s;
      `MFPR_CS_BCLK: cgen_nxt = bclk_s;
      `MFPR_CS_GPIO: cgen_nxt = gpio_is_in & gpio_s;
      `MFPR_CS_DIN: cgen_nxt = (din_fn == `MFPR_F2_SERIAL) & din_s;
      default: cgen_nxt = 1'b0;
    endcase
    case (conv_sel)
      `MFPR_CS_MCLK: conv_nxt = mclk_s;
      `MFPR_CS_BCLK: conv_nxt = bclk_s;
      `MFPR_CS_GPIO: conv_nxt = gpio_is_in & gpio_s;
      default: conv_nxt = 1'b0;
    endcase
  end

  // secondary port sources from the gpio or serial-clock pin
  always @*
  begin
    case (sec_src_r[`MFPR_SBCLK_HI:`MFPR_SBCLK_LO])
      `MFPR_SS_GPIO: sbclk_nxt = gpio_is_in & gpio_s;
      `MFPR_SS_SCLK: sbclk_nxt = sclk_is_in & sclk_s;
      default: sbclk_nxt = 1'b0;
    endcase
    case (sec_src_r[`MFPR_SWCLK_HI:`MFPR_SWCLK_LO])
      `MFPR_SS_GPIO: swclk_nxt = gpio_is_in & gpio_s;
      `MFPR_SS_SCLK: swclk_nxt = sclk_is_in & sclk_s;
      default: swclk_nxt = 1'b0;
    endcase
    if (sec_src_r[`MFPR_SDIN_SEL])
      sdin_nxt = sclk_is_in & sclk_s;
    else
      sdin_nxt = gpio_is_in & gpio_s;
  end

  // gpio/data-out pin: at most one source drives it
  always @*
  begin
    gpio_drv_nxt = 1'b1;
    gpio_val_nxt = 1'b0;
    case (gpio_fn)
      `MFPR_GF_AUX: gpio_val_nxt = aux_clk_in;
      `MFPR_GF_FIRST_INTERRUPT: gpio_val_nxt = first_interrupt_in;
      `MFPR_GF_SECOND_INTERRUPT: gpio_val_nxt = second_interrupt_in;
      `MFPR_GF_SBCLK: gpio_val_nxt = sec_bclk_in;
      `MFPR_GF_SWCLK: gpio_val_nxt = sec_wclk_in;
      `MFPR_GF_CLKIN: gpio_drv_nxt = 1'b0;
      `MFPR_GF_GPI: gpio_drv_nxt = 1'b0;
      default:
      begin
        // serial data output path, or other codes driven only by the general-purpose output source; output source picks the level
        case (gpio_src)
          `MFPR_GS_DOUT: gpio_val_nxt = pri_dout_in;
          `MFPR_GS_GPO: gpio_val_nxt = gpio_src_r[`MFPR_GP_LEVEL];
          default: gpio_drv_nxt = 1'b0;
        endcase
        if (gpio_fn != `MFPR_GF_DOUT && gpio_src != `MFPR_GS_GPO)
          gpio_drv_nxt = 1'b0;
      end
    endcase
  end

  // serial-data-out pin function
  always @*
  begin
    sout_drv_nxt = 1'b1;
    sout_val_nxt = 1'b0;
    case (sout_fn)
      `MFPR_SF_GPO: sout_val_nxt = sout_fn_r[`MFPR_LVL_BIT];
      `MFPR_SF_AUX: sout_val_nxt = aux_clk_in;
      `MFPR_SF_FIRST_INTERRUPT: sout_val_nxt = first_interrupt_in;
      `MFPR_SF_SECOND_INTERRUPT: sout_val_nxt = second_interrupt_in;
      `MFPR_SF_SDOUT: sout_val_nxt = sec_dout_in;
      `MFPR_SF_SBCLK: sout_val_nxt = sec_bclk_in;
      `MFPR_SF_SWCLK: sout_val_nxt = sec_wclk_in;
      default: sout_drv_nxt = 1'b0;
    endcase
  end

  // read data: stored value, with live pin levels in level bits
  always @*
  begin
    case (reg_addr_in)
      `MFPR_ADDR_CLK_SRC: rdata_nxt = clk_src_r;
      `MFPR_ADDR_AUD_DIR: rdata_nxt = aud_dir_r;
      `MFPR_ADDR_SEC_SRC: rdata_nxt = sec_src_r;
      `MFPR_ADDR_DOUT_CTL: rdata_nxt = dout_ctl_r;
      `MFPR_ADDR_GPIO_FN: rdata_nxt = {gpio_fn_r[7:2], (gpio_fn == `MFPR_GF_GPI) & gpio_s, gpio_fn_r[0]};
      `MFPR_ADDR_GPIO_SRC: rdata_nxt = gpio_src_r;
      `MFPR_ADDR_DIN_FN: rdata_nxt = {din_fn_r[7:1], (din_fn == `MFPR_F2_GPI) & din_s};
      `MFPR_ADDR_SOUT_FN: rdata_nxt = sout_fn_r;
      `MFPR_ADDR_SCLK_FN: rdata_nxt = {sclk_fn_r[7:1], (sclk_fn == `MFPR_F2_GPI) & sclk_s};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // registered outputs
  always @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      reg_rdata_out <= 8'h00;
      bclk_pin_out <= 1'b0;
      bclk_pin_oe_n_out <= 1'b1;
      wclk_pin_out <= 1'b0;
      wclk_pin_oe_n_out <= 1'b1;
      gpio_pin_out <= 1'b0;
      gpio_pin_oe_n_out <= 1'b1;
      sout_pin_out <= 1'b0;
      sout_pin_oe_n_out <= 1'b1;
      cgen_clk_out <= 1'b0;
      conv_clk_out <= 1'b0;
      pri_bclk_out <= 1'b0;
      pri_wclk_out <= 1'b0;
      pri_din_out <= 1'b0;
      sec_bclk_out <= 1'b0;
      sec_wclk_out <= 1'b0;
      sec_din_out <= 1'b0;
      dout_keep_out <= 1'b0;
    end
    else
    begin
      if (reg_rd_in)
        reg_rdata_out <= rdata_nxt;
      bclk_pin_out <= pri_bclk_in;
      bclk_pin_oe_n_out <= ~aud_dir_r[`MFPR_BCLK_DIR];
      pri_bclk_out <= aud_dir_r[`MFPR_BCLK_DIR] ? pri_bclk_in : bclk_s;
      wclk_pin_out <= pri_wclk_in;
      wclk_pin_oe_n_out <= ~aud_dir_r[`MFPR_WCLK_DIR];
      pri_wclk_out <= aud_dir_r[`MFPR_WCLK_DIR] ? pri_wclk_in : wclk_s;
      pri_din_out <= (din_fn == `MFPR_F2_SERIAL) & din_s;
      gpio_pin_out <= gpio_val_nxt;
      gpio_pin_oe_n_out <= ~gpio_drv_nxt;
      sout_pin_out <= sout_val_nxt;
      sout_pin_oe_n_out <= ~sout_drv_nxt;
      cgen_clk_out <= cgen_nxt;
      conv_clk_out <= conv_nxt;
      sec_bclk_out <= sbclk_nxt;
      sec_wclk_out <= swclk_nxt;
      sec_din_out <= sdin_nxt;
      dout_keep_out <= dout_ctl_r[1];
    end
  end
endmodule // mfpr_router

// ==== mfpr_router_asserts.sv ====
// mfpr_router_asserts.sv: timing checks on the multifunction pin router ports
// assumes: bound to mfpr_router; registers change only through reg_wr_in
`timescale 1ns/1ps
`include "mfpr_defs.vh"
module mfpr_router_asserts (
  input wire sys_clk_in,
  input wire rst_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire mclk_pin_in,
  input wire sclk_pin_in,
  input wire bclk_pin_out,
  input wire bclk_pin_oe_n_out,
  input wire wclk_pin_oe_n_out,
  input wire gpio_pin_out,
  input wire gpio_pin_oe_n_out,
  input wire sout_pin_out,
  input wire sout_pin_oe_n_out,
  input wire pri_bclk_in,
  input wire aux_clk_in,
  input wire first_interrupt_in,
  input wire sec_dout_in,
  input wire cgen_clk_out,
  input wire conv_clk_out,
  input wire sec_din_out,
  input wire dout_keep_out
);
  logic [7:0] sh_r [0:63];
  // shadow copy of every register write, cleared by reset
  always @(posedge sys_clk_in)
  begin
    for (int k = 0; k < 64; k++)
      sh_r[k] <= rst_in ? 8'h00 : (reg_wr_in && reg_addr_in == k) ? reg_wdata_in : sh_r[k];
  end
  // field views of the shadow registers
  wire [7:0] cs_w = sh_r[`MFPR_ADDR_CLK_SRC];
  wire [7:0] dir_w = sh_r[`MFPR_ADDR_AUD_DIR];
  wire [3:0] gf_w = sh_r[`MFPR_ADDR_GPIO_FN][5:2];
  wire [3:0] sf_w = sh_r[`MFPR_ADDR_SOUT_FN][4:1];
  wire [1:0] scf_w = sh_r[`MFPR_ADDR_SCLK_FN][2:1];
  wire sdsel_w = sh_r[`MFPR_ADDR_SEC_SRC][0];
  wire keep_w = sh_r[`MFPR_ADDR_DOUT_CTL][1];
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_mclk_sel;
    (cs_w[3:0] == 4'h0) [*4];
  endsequence
  sequence s_sclk_data;
    (scf_w == 2'h1 && sdsel_w) [*4];
  endsequence
  property p_clk_mclk;
    s_mclk_sel |-> cgen_clk_out == $past(mclk_pin_in, 3) && conv_clk_out == $past(mclk_pin_in, 3);
  endproperty
  a_clk_mclk: assert property (p_clk_mclk) else $error("clock selects miss master clock");
  property p_sec_din;
    s_sclk_data |-> sec_din_out == $past(sclk_pin_in, 3);
  endproperty
  a_sec_din: assert property (p_sec_din) else $error("secondary data not from serial clock pin");
  property p_bclk_dir;
    bclk_pin_oe_n_out == !$past(dir_w[3]);
  endproperty
  a_bclk_dir: assert property (p_bclk_dir) else $error("bit clock pin direction wrong");
  property p_wclk_dir;
    wclk_pin_oe_n_out == !$past(dir_w[2]);
  endproperty
  a_wclk_dir: assert property (p_wclk_dir) else $error("word clock pin direction wrong");
  property p_bclk_own;
    !bclk_pin_oe_n_out |-> bclk_pin_out == $past(pri_bclk_in);
  endproperty
  a_bclk_own: assert property (p_bclk_own) else $error("bit clock pin value wrong");
  property p_gpio_first_interrupt;
    $past(gf_w) == 4'h5 |-> !gpio_pin_oe_n_out && gpio_pin_out == $past(first_interrupt_in);
  endproperty
  a_gpio_first_interrupt: assert property (p_gpio_first_interrupt) else $error("gpio pin misses first interrupt");
  property p_gpio_in;
    $past(gf_w) inside {4'h1, 4'h2} |-> gpio_pin_oe_n_out;
  endproperty
  a_gpio_in: assert property (p_gpio_in) else $error("gpio pin driven while input");
  property p_sout_aux;
    $past(sf_w) == 4'h3 |-> !sout_pin_oe_n_out && sout_pin_out == $past(aux_clk_in);
  endproperty
  a_sout_aux: assert property (p_sout_aux) else $error("serial out pin misses aux clock");
  property p_sout_sec;
    $past(sf_w) == 4'h8 |-> !sout_pin_oe_n_out && sout_pin_out == $past(sec_dout_in);
  endproperty
  a_sout_sec: assert property (p_sout_sec) else $error("serial out pin misses secondary data");
  property p_keep;
    dout_keep_out == $past(keep_w);
  endproperty
  a_keep: assert property (p_keep) else $error("data output control bit not held");
  property p_read;
    reg_rd_in && reg_addr_in == `MFPR_ADDR_AUD_DIR |=> reg_rdata_out == $past(dir_w);
  endproperty
  a_read: assert property (p_read) else $error("direction register readback wrong");
endmodule // mfpr_router_asserts

// ==== mfpr_router_tb_top.sv ====
// mfpr_router_tb_top.sv: self-checking bench for the multifunction pin router
// assumes: router, pin peer and checker compiled first
`timescale 1ns/1ps
`include "mfpr_defs.vh"
`define CHK(n, e, g) chk(n, e, g)
module mfpr_router_tb_top;
  logic sys_clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, m [0:63];
  logic [5:0] peer = 0;
  logic [8:0] src = 0;
  logic [31:0] r;
  wire [5:0] pl;
  wire mclk_pin_in = pl[0], bclk_pin_in = pl[1], wclk_pin_in = pl[2];
  wire data_in_pin_in = pl[3], gpio_pin_in = pl[4], sclk_pin_in = pl[5];
  wire pri_bclk_in = src[0], pri_wclk_in = src[1], pri_dout_in = src[2], aux_clk_in = src[3];
  wire first_interrupt_in = src[4], second_interrupt_in = src[5], sec_bclk_in = src[6];
  wire sec_wclk_in = src[7], sec_dout_in = src[8];
  wire [7:0] reg_rdata_out;
  wire bclk_pin_out, bclk_pin_oe_n_out, wclk_pin_out, wclk_pin_oe_n_out, gpio_pin_out, gpio_pin_oe_n_out;
  wire sout_pin_out, sout_pin_oe_n_out, cgen_clk_out, conv_clk_out, pri_bclk_out, pri_wclk_out;
  wire pri_din_out, sec_bclk_out, sec_wclk_out, sec_din_out, dout_keep_out;
  integer error_cnt = 0, compares = 0, cyc = 0;
  logic [7:0] ads [10] = '{8'h04, 8'h1B, 8'h1F, 8'h21, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h10};
  mfpr_router u_mfpr_router (.*);
  mfpr_pin_peer u_mfpr_pin_peer (.peer_lvl_in(peer), .dev_bclk_in(bclk_pin_out), .dev_bclk_oe_n_in(bclk_pin_oe_n_out),
    .dev_wclk_in(wclk_pin_out), .dev_wclk_oe_n_in(wclk_pin_oe_n_out), .dev_gpio_in(gpio_pin_out),
    .dev_gpio_oe_n_in(gpio_pin_oe_n_out), .pin_lvl_out(pl));
  always #50 sys_clk_in = ~sys_clk_in;
  // cut a hang short
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  task close_out;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task do_reset;
    rst_in = 1;
    tick(2);
    rst_in = 0;
    for (int k = 0; k < 64; k++) m[k] = 8'h00;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1;
    tick(1);
    reg_wr_in = 0;
    m[a[5:0]] = d;
    tick(1);
  endtask
  // readback model: level bits replace stored ones, unmapped reads give zero
  function logic [7:0] exp_rd(input logic [7:0] a);
    logic [7:0] v;
    v = m[a[5:0]];
    case (a)
      8'h34: v[1] = (v[5:2] == 4'h2) & peer[4];
      8'h36: v[0] = (v[2:1] == 2'h2) & peer[3];
      8'h38: v[0] = (v[2:1] == 2'h2) & peer[5];
      8'h04, 8'h1B, 8'h1F, 8'h21, 8'h35, 8'h37: ;
      default: v = 8'h00;
    endcase
    return v;
  endfunction
  task rdc(input logic [7:0] a);
    reg_addr_in = a;
    reg_rd_in = 1;
    tick(1);
    reg_rd_in = 0;
    `CHK("rdata", exp_rd(a), reg_rdata_out);
    tick(1);
  endtask
  // routing model compared with every output
  task check_all;
    logic [3:0] gf, sf, cv;
    logic [2:0] gs;
    logic bw, ww, gi, si, di, ge, gv, se, sv;
    gf = m[8'h34][5:2];
    sf = m[8'h37][4:1];
    gs = m[8'h35][3:1];
    bw = m[8'h1B][3] ? src[0] : peer[1];
    ww = m[8'h1B][2] ? src[1] : peer[2];
    gi = (gf == 4'h1) & peer[4];
    si = (m[8'h38][2:1] == 2'h1) & peer[5];
    di = (m[8'h36][2:1] == 2'h1) & peer[3];
    cv = {di, gi, bw, peer[0]};
    ge = 1;
    se = 1;
    sv = 0;
    case (gf)
      4'h4: gv = src[3];
      4'h5: gv = src[4];
      4'h6: gv = src[5];
      4'h8: gv = src[6];
      4'h9: gv = src[7];
      4'hE: {ge, gv} = {gs == 3'h1 || gs == 3'h2, gs == 3'h1 ? src[2] : m[8'h35][0]};
      4'h1, 4'h2: {ge, gv} = 2'b00;
      default: {ge, gv} = {gs == 3'h2, m[8'h35][0]};
    endcase
    case (sf)
      4'h2: sv = m[8'h37][0];
      4'h3: sv = src[3];
      4'h4: sv = src[4];
      4'h5: sv = src[5];
      4'h8: sv = src[8];
      4'h9: sv = src[6];
      4'hA: sv = src[7];
      default: se = 0;
    endcase
    `CHK("cgen", cv[m[8'h04][3:2]], cgen_clk_out);
    `CHK("conv", m[8'h04][1:0] == 2'h3 ? 1'b0 : cv[m[8'h04][1:0]], conv_clk_out);
    `CHK("bclk_oe", !m[8'h1B][3], bclk_pin_oe_n_out);
    `CHK("wclk_oe", !m[8'h1B][2], wclk_pin_oe_n_out);
    if (m[8'h1B][3]) `CHK("bclk_pin", src[0], bclk_pin_out);
    if (m[8'h1B][2]) `CHK("wclk_pin", src[1], wclk_pin_out);
    `CHK("pri_bclk", bw, pri_bclk_out);
    `CHK("pri_wclk", ww, pri_wclk_out);
    `CHK("pri_din", di, pri_din_out);
    `CHK("gpio_oe", !ge, gpio_pin_oe_n_out);
    if (ge) `CHK("gpio", gv, gpio_pin_out);
    `CHK("sout_oe", !se, sout_pin_oe_n_out);
    if (se) `CHK("sout", sv, sout_pin_out);
    `CHK("sec_bclk", m[8'h1F][6:5] == 0 ? gi : m[8'h1F][6:5] == 1 ? si : 1'b0, sec_bclk_out);
    `CHK("sec_wclk", m[8'h1F][4:3] == 0 ? gi : m[8'h1F][4:3] == 1 ? si : 1'b0, sec_wclk_out);
    `CHK("sec_din", m[8'h1F][0] ? si : gi, sec_din_out);
    `CHK("keep", m[8'h21][1], dout_keep_out);
    foreach (ads[k]) rdc(ads[k]);
  endtask
  initial
  begin
    void'($urandom(32'h0916));
    do_reset;
    // sweep every code of each field, filler bits random
    for (int i = 0; i < 256; i++)
    begin
      r = $urandom;
      peer = r[5:0];
      src = r[14:6];
      wr(8'h04, {r[7:4], i[3:0]});
      wr(8'h1B, {r[11:8], i[1:0], r[1:0]});
      wr(8'h1F, {r[9], i[2:1], i[4:3], r[2:1], i[0]});
      wr(8'h21, r[23:16]);
      wr(8'h34, {r[31:30], i[3:0], r[1:0]});
      wr(8'h35, {r[27:24], i[6:4], r[3]});
      wr(8'h36, {r[22:18], i[5:4], r[4]});
      wr(8'h37, {r[15:13], i[7:4], r[5]});
      wr(8'h38, {r[29:25], i[1:0], r[6]});
      wr(8'h10, r[7:0]);
      tick(6);
      check_all;
    end
    // software sequence for primary serial data on the gpio pin
    wr(8'h21, 8'h00);
    wr(8'h35, 8'h02);
    wr(8'h34, 8'h38);
    tick(6);
    check_all;
    do_reset;
    tick(6);
    check_all;
    close_out;
  end
endmodule // mfpr_router_tb_top
bind mfpr_router mfpr_router_asserts u_mfpr_router_asserts (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .mclk_pin_in, .sclk_pin_in, .bclk_pin_out, .bclk_pin_oe_n_out,
  .wclk_pin_oe_n_out, .gpio_pin_out, .gpio_pin_oe_n_out, .sout_pin_out, .sout_pin_oe_n_out, .pri_bclk_in,
  .aux_clk_in, .first_interrupt_in, .sec_dout_in, .cgen_clk_out, .conv_clk_out, .sec_din_out, .dout_keep_out);

// ==== mfpr_sync.v ====
// mfpr_sync.v: two-flop synchroniser bank for asynchronous pin levels
// assumes: inputs come from pins outside the sys_clk_in domain
`timescale 1ns/1ps
module mfpr_sync #(
  parameter W = 7
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  genvar i;
  // one two-stage chain per pin; first stage feeds only the second
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      reg meta_r;
      reg stable_r;
      always @(posedge sys_clk_in)
      begin
        if (rst_in)
        begin
          meta_r <= 1'b0;
          stable_r <= 1'b0;
        end
        else
        begin
          meta_r <= async_in[i];
          stable_r <= meta_r;
        end
      end
      assign sync_out[i] = stable_r;
    end
  endgenerate
endmodule // mfpr_sync
